// >>> delay_timer.sv
`timescale 1ns/1ps
module delay_timer #(
  parameter logic [15:0] LIMIT = 16'h0bb8
) (
  input  wire logic clk_in,    // System clock
  input  wire logic arst_n_in, // Async reset, active low
  delay_timer_if.tmr tif       // Arm, tick and expiry
);
  relay_pkg::timer_state_t st;
  relay_pkg::timer_state_t next_st;

  // Count ticks while armed; clear on disarm; hold at limit
  always_comb begin
    next_st = st;
    if (!tif.arm) begin
      next_st = '0;
    end else if (tif.tick && st.count != LIMIT) begin
      next_st.count = st.count + 16'h0001;
    end
    next_st.expired = tif.arm && (next_st.count == LIMIT);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tif.expired = st.expired;
endmodule : delay_timer

// >>> delay_timer_if.sv
`timescale 1ns/1ps
interface delay_timer_if;
  logic arm;
  logic tick;
  logic expired;
  modport ctl (output arm, output tick, input expired);
  modport tmr (input arm, input tick, output expired);
endinterface : delay_timer_if

// >>> input_sync.sv
`timescale 1ns/1ps
module input_sync (
  input  wire logic       clk_in,    // System clock
  input  wire logic       arst_n_in, // Async reset, active low
  input  wire logic [7:0] d_in,      // Raw pin levels
  output logic      [7:0] q_out      // Filtered levels
);
  relay_pkg::sync_state_t st;
  relay_pkg::sync_state_t next_st;

  // Three stages; accept a change once stages two and three agree
  always_comb begin
    next_st    = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 8; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.q;
endmodule : input_sync

// >>> relay_aux_model.sv
`timescale 1ns/1ps
module relay_aux_model (
  input  wire logic       clk_in,          // System clock
  input  wire logic [3:0] coil_in,         // Coil drives
  input  wire logic [3:0] drive_in,        // Feedback send
  input  wire logic       slow_in,         // Slow contact travel
  input  wire logic [3:0] stuck_open_in,   // Contacts welded open
  input  wire logic [3:0] stuck_closed_in, // Contacts welded closed
  output logic      [3:0] sense_out        // Feedback return
);
  logic [7:0][3:0] travel = '0;
  logic [3:0]      last   = 4'h0;
  logic [3:0]      contacts;

  // Contacts follow the coil after a short or long travel time
  always_ff @(posedge clk_in) begin
    travel <= {travel[6:0], coil_in};
  end
  assign contacts = ((slow_in ? travel[4] : travel[1]) | stuck_closed_in) & ~stuck_open_in;

  // Unpowered return floats, so it shows the inverse of the last level
  always_ff @(posedge clk_in) begin
    last <= (drive_in & contacts) | (~drive_in & ~last);
  end
  assign sense_out = last;
endmodule : relay_aux_model

// >>> relay_consts.svh
`ifndef RELAY_CONSTS_SVH
`define RELAY_CONSTS_SVH
// Clock and timing base
`define RLY_CLK_PERIOD_NS  10
`define RLY_TICK_NS        1000000
`define RLY_TICK_CYCLES    (`RLY_TICK_NS / `RLY_CLK_PERIOD_NS)
`define RLY_ILK_DELAY_S    3
`define RLY_HARD_DELAY_S   2
`define RLY_SOFT_DELAY_S   20
`define RLY_ILK_DELAY_MS   (`RLY_ILK_DELAY_S * 1000)
`define RLY_HARD_DELAY_MS  (`RLY_HARD_DELAY_S * 1000)
`define RLY_SOFT_DELAY_MS  (`RLY_SOFT_DELAY_S * 1000)
`define RLY_FB_SETTLE_MS   50
// Register byte offsets
`define RLY_OFS_CTRL       8'h00
`define RLY_OFS_ALARM      8'h04
`define RLY_OFS_CFG        8'h08
`define RLY_OFS_STATUS     8'h0c
`define RLY_OFS_FAULT      8'h10
// Field positions
`define RLY_CTRL_REARM     8
`define RLY_ALM_WARN       0
`define RLY_ALM_SOFT       1
`define RLY_ALM_HARD       2
`define RLY_ALM_SENSOR     3
`define RLY_CFG_MASK_LSB   8
// Reset values
`define RLY_RST_CMD        4'h0
`define RLY_RST_FB_EN      4'h0
`define RLY_RST_SAFE_MASK  4'h3
`endif

// >>> relay_interlock_control.sv
`timescale 1ns/1ps
`include "relay_consts.svh"
// How it works
// - Four independent relay coil outputs are each commanded open or closed by software.
// - Every coil output is gated by the shared interlock so a close needs an interlock that is not disabled.
// - The interlock trips when the module interlock or the safety loop reports a fault.
// - Three seconds after a trip all coil outputs are disabled regardless of commands.
// - Relays one to three obey commands on either supply input.
// - Relay four closes only while supply A is active and supply B is off.
// - A hard shutdown alarm opens the safety relays after two seconds.
// - Each relay has an optional feedback input sampled as a digital level.
// - A command and feedback mismatch raises a failed-open or failed-closed flag.
// - A sensor fault alarm is flagged only and control carries on.
// - A soft shutdown alarm opens the safety relays after twenty seconds.
// - A warning alarm is reported only and causes no relay action.
module relay_interlock_control #(
  parameter logic [16:0] TICK_CYCLES     = 17'(`RLY_TICK_CYCLES),
  parameter logic [15:0] ILK_DELAY_TICKS = 16'(`RLY_ILK_DELAY_MS),
  parameter logic [15:0] HARD_TICKS      = 16'(`RLY_HARD_DELAY_MS),
  parameter logic [15:0] SOFT_TICKS      = 16'(`RLY_SOFT_DELAY_MS),
  parameter logic [7:0]  FB_SETTLE_TICKS = 8'(`RLY_FB_SETTLE_MS)
) (
  input  wire logic        clk_in,                    // System clock 100 MHz
  input  wire logic        arst_n_in,                 // Async reset, active low
  input  wire logic        psel_in,                   // APB select
  input  wire logic        penable_in,                // APB enable
  input  wire logic        pwrite_in,                 // APB direction
  input  wire logic [7:0]  paddr_in,                  // APB byte address
  input  wire logic [31:0] pwdata_in,                 // APB write data
  output logic             pready_out,                // APB ready
  output logic      [31:0] prdata_out,                // APB read data
  output logic             pslverr_out,               // APB error
  input  wire logic        module_interlock_in,       // Module interlock, high healthy
  input  wire logic        safety_loop_interlock_in,  // Safety loop, high healthy
  input  wire logic        supply_a_active_in,        // Powered from supply A
  input  wire logic        supply_b_active_in,        // Supply B on
  input  wire logic [3:0]  relay_feedback_sense_in,   // Aux contact returns
  output logic      [3:0]  relay_feedback_drive_out,  // Aux contact sends
  output logic      [3:0]  relay_coil_drive_out       // Relay coil drives
);
  relay_pkg::ctrl_state_t st;
  relay_pkg::ctrl_state_t next_st;
  logic [7:0]             sync_q;
  logic [3:0]             fb_s;
  logic                   mod_ok;
  logic                   loop_ok;
  logic                   sup_a;
  logic                   sup_b;
  logic                   healthy;
  logic                   sup_ok;
  logic                   wr;
  logic                   rd_setup;
  logic                   rearm;
  logic [3:0]             shut;
  logic [3:0]             mismatch;
  logic [3:0]             set_open;
  logic [3:0]             set_closed;
  logic [3:0]             clr_open;
  logic [3:0]             clr_closed;

  delay_timer_if ilk_tif ();
  delay_timer_if hard_tif ();
  delay_timer_if soft_tif ();

  // Pin inputs through three-stage filter
  input_sync u_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .d_in      ({supply_b_active_in, supply_a_active_in, safety_loop_interlock_in,
                 module_interlock_in, relay_feedback_sense_in}),
    .q_out     (sync_q)
  );

  assign fb_s    = sync_q[3:0];
  assign mod_ok  = sync_q[4];
  assign loop_ok = sync_q[5];
  assign sup_a   = sync_q[6];
  assign sup_b   = sync_q[7];
  assign healthy = mod_ok && loop_ok;
  assign sup_ok  = sup_a && !sup_b;

  // Delay timers: interlock, hard and soft shutdown
  assign ilk_tif.arm  = (st.ilk == relay_pkg::ILK_DELAY);
  assign ilk_tif.tick = st.tick;
  assign hard_tif.arm  = st.alarm[`RLY_ALM_HARD];
  assign hard_tif.tick = st.tick;
  assign soft_tif.arm  = st.alarm[`RLY_ALM_SOFT];
  assign soft_tif.tick = st.tick;

  delay_timer #(.LIMIT(ILK_DELAY_TICKS)) u_ilk_tmr (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tif       (ilk_tif.tmr)
  );

  delay_timer #(.LIMIT(HARD_TICKS)) u_hard_tmr (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tif       (hard_tif.tmr)
  );

  delay_timer #(.LIMIT(SOFT_TICKS)) u_soft_tmr (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tif       (soft_tif.tmr)
  );

  // Bus strobes
  assign wr       = psel_in && penable_in && pwrite_in;
  assign rd_setup = psel_in && !penable_in;
  assign rearm    = wr && (paddr_in == `RLY_OFS_CTRL) && pwdata_in[`RLY_CTRL_REARM];

  // Safety relays opened by expired shutdown timers; warning and sensor bits unused here
  assign shut = (hard_tif.expired || soft_tif.expired) ? st.safe_mask : 4'h0;

  // Feedback compare and fault set/clear terms
  always_comb begin
    clr_open   = 4'h0;
    clr_closed = 4'h0;
    if (wr && paddr_in == `RLY_OFS_FAULT) begin
      clr_open   = pwdata_in[3:0];
      clr_closed = pwdata_in[7:4];
    end
    for (int i = 0; i < 4; i++) begin
      mismatch[i]   = st.fb_en[i] && (st.coil[i] != fb_s[i]);
      set_open[i]   = mismatch[i] && st.coil[i] && (st.settle[i] == FB_SETTLE_TICKS);
      set_closed[i] = mismatch[i] && !st.coil[i] && (st.settle[i] == FB_SETTLE_TICKS);
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    next_st     = st;
    next_st.tick = 1'b0;
    if (st.div == TICK_CYCLES - 17'h00001) begin
      next_st.div  = 17'h00000;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 17'h00001;
    end

    // Interlock sequence
    case (st.ilk)
      relay_pkg::ILK_ARMED: begin
        if (!healthy) begin
          next_st.ilk = relay_pkg::ILK_DELAY;
        end
      end
      relay_pkg::ILK_DELAY: begin
        if (healthy) begin
          next_st.ilk = relay_pkg::ILK_ARMED;
        end else if (ilk_tif.expired) begin
          next_st.ilk = relay_pkg::ILK_DISABLED;
        end
      end
      relay_pkg::ILK_DISABLED: begin
        if (rearm && healthy) begin
          next_st.ilk = relay_pkg::ILK_ARMED;
        end
      end
      default: begin
        next_st.ilk = relay_pkg::ILK_DISABLED;
      end
    endcase

    // Coil outputs: command, interlock gate, supply gate on relay four
    next_st.coil = st.cmd & ~shut
                 & {4{st.ilk != relay_pkg::ILK_DISABLED}}
                 & {sup_ok, 3'b111};
    next_st.fb_drive = st.fb_en;

    // Mismatch settle counters per relay
    for (int i = 0; i < 4; i++) begin
      if (!mismatch[i]) begin
        next_st.settle[i] = 8'h00;
      end else if (st.tick && st.settle[i] != FB_SETTLE_TICKS) begin
        next_st.settle[i] = st.settle[i] + 8'h01;
      end
    end
    // Sticky faults, set wins over clear
    next_st.fail_open   = (st.fail_open & ~clr_open) | set_open;
    next_st.fail_closed = (st.fail_closed & ~clr_closed) | set_closed;

    // Register writes at the access phase
    if (wr) begin
      case (paddr_in)
        `RLY_OFS_CTRL: begin
          next_st.cmd = pwdata_in[3:0];
        end
        `RLY_OFS_ALARM: begin
          next_st.alarm = pwdata_in[3:0];
        end
        `RLY_OFS_CFG: begin
          next_st.fb_en     = pwdata_in[3:0];
          next_st.safe_mask = pwdata_in[`RLY_CFG_MASK_LSB +: 4];
        end
        default: begin
        end
      endcase
    end

    // Read data and error captured in the setup cycle
    if (rd_setup) begin
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h00000000;
      case (paddr_in)
        `RLY_OFS_CTRL:   next_st.prdata = {28'h0000000, st.cmd};
        `RLY_OFS_ALARM:  next_st.prdata = {28'h0000000, st.alarm};
        `RLY_OFS_CFG:    next_st.prdata = {20'h00000, st.safe_mask, 4'h0, st.fb_en};
        `RLY_OFS_STATUS: next_st.prdata = {16'h0000, st.ilk, soft_tif.expired,
                                           hard_tif.expired, fb_s, sup_b, sup_a,
                                           (st.ilk != relay_pkg::ILK_ARMED), !healthy,
                                           st.coil};
        `RLY_OFS_FAULT:  next_st.prdata = {24'h000000, st.fail_closed, st.fail_open};
        default:         next_st.pslverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st           <= '0;
      st.ilk       <= relay_pkg::ILK_ARMED;
      st.cmd       <= `RLY_RST_CMD;
      st.fb_en     <= `RLY_RST_FB_EN;
      st.safe_mask <= `RLY_RST_SAFE_MASK;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign pready_out               = 1'b1;
  assign prdata_out               = st.prdata;
  assign pslverr_out              = st.pslverr;
  assign relay_coil_drive_out     = st.coil;
  assign relay_feedback_drive_out = st.fb_drive;

  // Helper: ticks seen while in the delay state
  logic [15:0] delay_ticks;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      delay_ticks <= 16'h0000;
    end else if (st.ilk != relay_pkg::ILK_DELAY) begin
      delay_ticks <= 16'h0000;
    end else if (st.tick && delay_ticks != ILK_DELAY_TICKS) begin
      delay_ticks <= delay_ticks + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // Checks
  sequence s_trip_armed;
    (st.ilk == relay_pkg::ILK_ARMED) && !healthy;
  endsequence

  sequence s_left_delay;
    ##1 (st.ilk == relay_pkg::ILK_DELAY);
  endsequence

  a_coil_follows_cmd: assert property (
    (st.coil & ~$past(st.cmd)) == 4'h0)
    else $error("coil closed without command");

  a_gate_disabled: assert property (
    st.ilk == relay_pkg::ILK_DISABLED |=> st.coil == 4'h0)
    else $error("coil closed while interlock disabled");

  a_trip_detect: assert property (
    s_trip_armed |-> s_left_delay)
    else $error("interlock fault not detected");

  a_disable_delay: assert property (
    $rose(st.ilk == relay_pkg::ILK_DISABLED)
      |-> $past(st.ilk) == relay_pkg::ILK_DELAY && delay_ticks == ILK_DELAY_TICKS)
    else $error("outputs disabled at wrong delay");

  a_supply_b_ok: assert property (
    st.cmd[0] && sup_b && st.ilk == relay_pkg::ILK_ARMED && shut == 4'h0
      |=> st.coil[0])
    else $error("relay one blocked by supply");

  a_relay4_supply: assert property (
    (!sup_a || sup_b) |=> !st.coil[3])
    else $error("relay four closed off supply A");

  a_hard_open: assert property (
    hard_tif.expired |=> (st.coil & $past(st.safe_mask)) == 4'h0)
    else $error("safety relay closed after hard alarm");

  a_soft_open: assert property (
    soft_tif.expired |=> (st.coil & $past(st.safe_mask)) == 4'h0)
    else $error("safety relay closed after soft alarm");

  a_fail_open_cause: assert property (
    (st.fail_open & ~$past(st.fail_open)) != 4'h0
      |-> $past((st.coil & ~fb_s & st.fb_en) != 4'h0))
    else $error("failed-open flag without mismatch");

  a_disable_held: assert property (
    st.ilk == relay_pkg::ILK_DISABLED && !(rearm && healthy)
      |=> st.ilk == relay_pkg::ILK_DISABLED)
    else $error("outputs re-enabled without re-arm");
endmodule : relay_interlock_control

// >>> relay_interlock_control_test.sv
`timescale 1ns/1ps
module relay_interlock_control_test;
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, mod_ok = 1'b1, loop_ok = 1'b1, sup_a = 1'b1, sup_b = 1'b0;
  logic        slow = 1'b0;
  logic [3:0]  sense, fb_drive, coil, st_open = 4'h0, st_closed = 4'h0, cmd;
  int          n_mismatch = 0, n_checks = 0, seed = 32'h9a72;
  int          early[2] = '{6, 6};
  int          late[2] = '{30, 30};

  relay_interlock_control #(
    .TICK_CYCLES(17'h00004), .ILK_DELAY_TICKS(16'h0005), .HARD_TICKS(16'h0004),
    .SOFT_TICKS(16'h0008), .FB_SETTLE_TICKS(8'h06)
  ) relay_interlock_control_i (
    .clk_in(clk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .module_interlock_in(mod_ok),
    .safety_loop_interlock_in(loop_ok), .supply_a_active_in(sup_a),
    .supply_b_active_in(sup_b), .relay_feedback_sense_in(sense),
    .relay_feedback_drive_out(fb_drive), .relay_coil_drive_out(coil));

  relay_aux_model relay_aux_model_i (
    .clk_in(clk), .coil_in(coil), .drive_in(fb_drive), .slow_in(slow),
    .stuck_open_in(st_open), .stuck_closed_in(st_closed), .sense_out(sense));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Compare one value
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // One APB transfer, waiting for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_mismatch++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Coil expected from command and supplies
  function automatic logic [3:0] exp_coil(input logic [3:0] c, input logic a, input logic b);
    return c & {a & ~b, 3'b111};
  endfunction : exp_coil

  initial begin
    cyc(10);
    arst_n <= 1'b1;
    cyc(10);
    // Reset values and unmapped place
    apb(1'b0, 8'h00, 32'h0); check("ctrl", rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0); check("cfg", rd, 32'h300);
    apb(1'b0, 8'h14, 32'h0); check("unmapped", {rd[30:0], err}, 32'h1);
    // Random commands under random supplies
    repeat (24) begin
      cmd = 4'($random(seed));
      sup_a <= 1'($random(seed));
      sup_b <= 1'($random(seed));
      apb(1'b1, 8'h00, {28'h0, cmd});
      cyc(6);
      check("coil", coil, exp_coil(cmd, sup_a, sup_b));
      apb(1'b0, 8'h00, 32'h0); check("ctrl", rd[3:0], cmd);
    end
    sup_a <= 1'b1;
    sup_b <= 1'b1;
    apb(1'b1, 8'h00, 32'hf);
    cyc(6);
    check("coil4 b on", coil, 32'h7);
    sup_b <= 1'b0;
    cyc(6);
    check("coil a only", coil, 32'hf);
    // Warning and sensor fault leave relays alone
    apb(1'b1, 8'h04, 32'h9);
    cyc(60);
    check("coil warn", coil, 32'hf);
    apb(1'b0, 8'h04, 32'h0); check("alarm", rd, 32'h9);
    // Soft then hard shutdown open the masked relays on time
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 8'h04, k ? 32'h4 : 32'h2);
      cyc(early[k]);
      check("coil early", coil, 32'hf);
      cyc(late[k]);
      check("coil shut", coil, 32'hc);
      apb(1'b1, 8'h04, 32'h0);
      cyc(6);
      check("coil release", coil, 32'hf);
    end
    // Feedback: healthy slow relays, then welded ones
    slow <= 1'b1;
    apb(1'b1, 8'h08, 32'h30f);
    cyc(3);
    check("fb drive", fb_drive, 32'hf);
    cyc(60);
    apb(1'b0, 8'h10, 32'h0); check("no fault", rd, 32'h0);
    apb(1'b1, 8'h00, 32'hd);
    st_open <= 4'h1;
    st_closed <= 4'h2;
    cyc(70);
    apb(1'b0, 8'h10, 32'h0); check("fault", rd[7:0], 32'h21);
    st_open <= 4'h0;
    st_closed <= 4'h0;
    cyc(20);
    apb(1'b1, 8'h10, 32'h21);
    apb(1'b0, 8'h10, 32'h0); check("fault clr", rd, 32'h0);
    apb(1'b1, 8'h00, 32'hf);
    // Trip each interlock source, disable, then re-arm
    for (int k = 0; k < 2; k++) begin
      if (k) loop_ok <= 1'b0; else mod_ok <= 1'b0;
      cyc(10);
      check("coil delay", coil, 32'hf);
      cyc(40);
      check("coil trip", coil, 32'h0);
      // Disabled state, fault seen, supply A only, contacts open
      apb(1'b0, 8'h0c, 32'h0); check("status", rd, 32'h8070);
      mod_ok <= 1'b1;
      loop_ok <= 1'b1;
      cyc(20);
      check("coil held", coil, 32'h0);
      apb(1'b1, 8'h00, 32'h10f);
      cyc(6);
      check("coil rearm", coil, 32'hf);
    end
    // Brief trip that heals within the delay
    loop_ok <= 1'b0;
    cyc(8);
    loop_ok <= 1'b1;
    cyc(40);
    check("coil healed", coil, 32'hf);
    finish_test();
  end
endmodule : relay_interlock_control_test

// >>> relay_pkg.sv
package relay_pkg;
  typedef enum logic [1:0] {
    ILK_ARMED    = 2'b00,
    ILK_DELAY    = 2'b01,
    ILK_DISABLED = 2'b10
  } ilk_state_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] q;
  } sync_state_t;

  typedef struct packed {
    logic [15:0] count;
    logic        expired;
  } timer_state_t;

  typedef struct packed {
    ilk_state_t      ilk;
    logic [3:0]      cmd;
    logic [3:0]      alarm;
    logic [3:0]      fb_en;
    logic [3:0]      safe_mask;
    logic [3:0]      coil;
    logic [3:0]      fb_drive;
    logic [3:0]      fail_open;
    logic [3:0]      fail_closed;
    logic [3:0][7:0] settle;
    logic [16:0]     div;
    logic            tick;
    logic [31:0]     prdata;
    logic            pslverr;
  } ctrl_state_t;
endpackage : relay_pkg
